//--- logic/dbxc_pkg.sv
// Package of constants and types for the debug breakpoint and exception controller
package dbxc_pkg;

	// ----------------------------------------
	// Register map (word index on command port)
	// ----------------------------------------
	localparam logic [3:0]  DBXC_ADDR_DR0        = 4'h0;  // Breakpoint address 0..3 at 0..3
	localparam logic [3:0]  DBXC_ADDR_ALIAS_FOUR = 4'h4;
	localparam logic [3:0]  DBXC_ADDR_ALIAS_FIVE = 4'h5;
	localparam logic [3:0]  DBXC_ADDR_DSTATUS    = 4'h6;
	localparam logic [3:0]  DBXC_ADDR_DCTRL      = 4'h7;
	localparam logic [3:0]  DBXC_ADDR_FEATURE    = 4'h8;
	localparam logic [3:0]  DBXC_ADDR_PFP_CSR    = 4'h9;
	localparam logic [3:0]  DBXC_ADDR_LAST_VEC   = 4'ha;

	// ----------------------------------------
	// Field layouts and reset values
	// ----------------------------------------
	localparam logic [31:0] DBXC_DCTRL_RSVD_MASK   = 32'h0000_d800;  // Bits 11,12,14,15
	localparam logic [31:0] DBXC_DSTATUS_RSVD_MASK = 32'h0000_1000;  // Bit 12
	localparam logic [31:0] DBXC_DCTRL_RESET       = 32'h0000_0400;
	localparam logic [31:0] DBXC_DSTATUS_RESET     = 32'hffff_0ff0;
	localparam logic [31:0] DBXC_FEATURE_RESET     = 32'h0000_0000;
	localparam logic [31:0] DBXC_FEATURE_VALID     = 32'h0000_07ff;  // Writable feature bits
	localparam int          DBXC_FEAT_DEBUG_EXT    = 3;
	localparam int          DBXC_FEAT_MCHK         = 6;
	localparam int          DBXC_DCTRL_TYPE_LSB    = 16;  // Type field of breakpoint n at 16+4n
	localparam int          DBXC_DCTRL_LEN_LSB     = 18;
	localparam logic [7:0]  DBXC_INVALID_AR_A      = 8'h80;
	localparam logic [7:0]  DBXC_INVALID_AR_B      = 8'h00;
	localparam logic [3:0]  DBXC_MAX_INSN_LEN      = 4'hf;   // 15 bytes

	// ----------------------------------------
	// Breakpoint access types
	// ----------------------------------------
	localparam logic [1:0]  DBXC_BP_EXEC  = 2'h0;
	localparam logic [1:0]  DBXC_BP_WRITE = 2'h1;
	localparam logic [1:0]  DBXC_BP_IO    = 2'h2;
	localparam logic [1:0]  DBXC_BP_RW    = 2'h3;

	// ----------------------------------------
	// Exception vectors
	// ----------------------------------------
	localparam logic [7:0]  DBXC_VEC_DIVIDE = 8'h00;
	localparam logic [7:0]  DBXC_VEC_DEBUG  = 8'h01;
	localparam logic [7:0]  DBXC_VEC_INV_OP = 8'h06;
	localparam logic [7:0]  DBXC_VEC_GP     = 8'h0d;
	localparam logic [7:0]  DBXC_VEC_PAGE   = 8'h0e;
	localparam logic [7:0]  DBXC_VEC_ALIGN  = 8'h11;
	localparam logic [7:0]  DBXC_VEC_MCHK   = 8'h12;
	localparam logic [7:0]  DBXC_VEC_PFP    = 8'h13;

	// Access kind reported by the pipeline
	typedef enum logic [1:0] {
		DBXC_ACC_FETCH,
		DBXC_ACC_READ,
		DBXC_ACC_WRITE,
		DBXC_ACC_IO
	} dbxc_acc_t;

endpackage : dbxc_pkg

//--- logic/dbxc_bp_match.sv
// Breakpoint type decode and address match for one breakpoint slot
`timescale 1ns/1ps
module dbxc_bp_match
	import dbxc_pkg::*;
(
	// Slot configuration
	input  wire logic [31:0] bp_addr_in,
	input  wire logic [1:0]  access_type_in,
	input  wire logic [1:0]  bp_len_in,
	input  wire logic        debug_ext_enable_in,
	// Access being checked
	input  wire logic        acc_valid_in,
	input  wire dbxc_acc_t   acc_kind_in,
	input  wire logic [31:0] acc_addr_in,
	// Result
	output logic             hit_out
);

	// Length mask ignores low address bits within the watched span
	wire logic [31:0] len_mask;
	wire logic        addr_eq;
	wire logic        type_ok;

	assign len_mask = {30'h3fff_ffff, ~bp_len_in};
	assign addr_eq  = ((bp_addr_in ^ acc_addr_in) & len_mask) == 32'h0000_0000;

	// Kind filter per access-type field
	assign type_ok =
		(access_type_in == DBXC_BP_EXEC)  ? (acc_kind_in == DBXC_ACC_FETCH) :
		(access_type_in == DBXC_BP_WRITE) ? (acc_kind_in == DBXC_ACC_WRITE) :
		(access_type_in == DBXC_BP_IO)    ? (debug_ext_enable_in &&
		                                     acc_kind_in == DBXC_ACC_IO) :
		((acc_kind_in == DBXC_ACC_READ) || (acc_kind_in == DBXC_ACC_WRITE));

	assign hit_out = acc_valid_in && addr_eq && type_ok;

endmodule : dbxc_bp_match

//--- logic/dbxc_prio.sv
// Fixed-priority picker across the five event categories
`timescale 1ns/1ps
module dbxc_prio
	import dbxc_pkg::*;
(
	// Requests and vectors per category, index 0 is highest
	input  wire logic [4:0]  req_in,
	input  wire logic [39:0] vec_in,
	// Winner
	output logic             any_out,
	output logic [7:0]       vec_out,
	output logic [2:0]       cat_out
);

	// Lowest index wins; ties resolve the same way every time
	always_comb begin
		any_out = 1'b0;
		vec_out = 8'h00;
		cat_out = 3'h0;
		for (int i = 4; i >= 0; i--) begin
			if (req_in[i]) begin
				any_out = 1'b1;
				vec_out = vec_in[i*8 +: 8];
				cat_out = 3'(i);
			end
		end
	end

endmodule : dbxc_prio

//--- logic/dbxc_ctrl.sv
// Debug breakpoint decode, debug register access and exception ranking
//
// The address map and the strobed register port were left to the implementer.
`timescale 1ns/1ps

// Summary of operation
// - Type 00 breaks only on instruction execution at the address.
// - Type 01 breaks only on data writes to the address.
// - Type 10 with debug extensions on breaks on I/O reads or writes.
// - Type 11 breaks on data reads or writes, never fetches.
// - Debug control bits 11, 12, 14, 15 always read zero.
// - Debug status bit 12 can never be written to one.
// - Extensions off: register four aliases status, five aliases control.
// - Extensions on: touching register four or five is invalid opcode.
// - Moves to or from legacy test registers are invalid opcode.
// - Machine check on vector 18 only while its enable is set.
// - Writing one to a reserved special-register bit is protection fault 13.
// - Reserved bit set in a translation entry gives page fault 14.
// - With alignment checking active, unaligned reference gives fault 17.
// - Packed float errors go to vector 19 and are recorded in status.
// - Divide error vector 0 saves pointer to the divide itself.
// - Most negative signed quotient is a valid result, no divide error.
// - Improper lock prefix gives invalid opcode on vector 6.
// - Instruction longer than 15 bytes gives protection fault.
// - Rank: prior traps, interrupts, fetch, decode, execute faults.
// - Descriptor load does locked accessed-bit update only if bit clear.
// - Access-rights values 80 and 00 are invalid descriptor types.
// - Feature control register clears fully on hardware reset.
module dbxc_ctrl
	import dbxc_pkg::*;
(
	// Clock and reset
	input  wire logic        ref_clk_in,
	input  wire logic        rst_in,
	// Register command port
	input  wire logic [3:0]  reg_addr_in,
	input  wire logic [31:0] reg_wdata_in,
	input  wire logic        reg_wr_in,
	input  wire logic        reg_rd_in,
	output logic [31:0]      reg_rdata_out,
	// Memory and I/O access from execute
	input  wire logic        acc_valid_in,
	input  wire dbxc_acc_t   acc_kind_in,
	input  wire logic [31:0] acc_addr_in,
	input  wire logic [1:0]  acc_size_in,
	input  wire logic        align_check_active_in,
	// Decode reports
	input  wire logic        test_reg_move_in,
	input  wire logic        lock_misuse_in,
	input  wire logic [3:0]  insn_len_in,
	input  wire logic        insn_len_ovf_in,
	input  wire logic        fetch_fault_in,
	input  wire logic [7:0]  fetch_fault_vec_in,
	// Execute reports
	input  wire logic [31:0] insn_ptr_in,
	input  wire logic        div_valid_in,
	input  wire logic        div_signed_in,
	input  wire logic        div_word_in,
	input  wire logic [32:0] div_quot_in,
	input  wire logic        div_by_zero_in,
	input  wire logic        pt_rsvd_set_in,
	input  wire logic        pfp_error_in,
	input  wire logic [5:0]  pfp_flags_in,
	input  wire logic        hw_error_in,
	input  wire logic        prev_trap_in,
	input  wire logic        ext_irq_in,
	input  wire logic [7:0]  ext_irq_vec_in,
	input  wire logic        sreg_wr_in,
	input  wire logic [31:0] sreg_wdata_in,
	input  wire logic [31:0] sreg_rsvd_mask_in,
	// Descriptor loads
	input  wire logic        desc_load_in,
	input  wire logic [7:0]  desc_ar_in,
	// Event delivery
	output logic             event_valid_out,
	output logic [7:0]       event_vec_out,
	output logic [2:0]       event_cat_out,
	output logic [31:0]      event_ret_ptr_out,
	// Descriptor results
	output logic             desc_locked_rmw_out,
	output logic             desc_invalid_out,
	// Feature state
	output logic             debug_ext_enable_out,
	output logic             machine_check_enable_out
);

	// ----------------------------------------
	// Register state
	// ----------------------------------------
	logic [31:0] bp_addr_q [4];
	logic [31:0] debug_control_reg_q;
	logic [31:0] debug_status_reg_q;
	logic [31:0] feature_control_reg_q;
	logic [31:0] packed_fp_ctrl_status_q;
	logic [7:0]  last_vec_q;
	logic [31:0] reg_rdata_q;

	wire logic debug_ext_enable     = feature_control_reg_q[DBXC_FEAT_DEBUG_EXT];
	wire logic machine_check_enable = feature_control_reg_q[DBXC_FEAT_MCHK];

	// ----------------------------------------
	// Register address decode
	// ----------------------------------------
	wire logic is_alias = (reg_addr_in == DBXC_ADDR_ALIAS_FOUR) ||
	                      (reg_addr_in == DBXC_ADDR_ALIAS_FIVE);
	wire logic alias_fault = is_alias && (reg_wr_in || reg_rd_in) &&
	                         debug_ext_enable;
	// Extensions off: four and five land on status and control
	wire logic sel_status = (reg_addr_in == DBXC_ADDR_DSTATUS) ||
	                        (reg_addr_in == DBXC_ADDR_ALIAS_FOUR && !debug_ext_enable);
	wire logic sel_ctrl   = (reg_addr_in == DBXC_ADDR_DCTRL) ||
	                        (reg_addr_in == DBXC_ADDR_ALIAS_FIVE && !debug_ext_enable);
	wire logic sel_bp     = (reg_addr_in[3:2] == DBXC_ADDR_DR0[3:2]);
	wire logic feat_rsvd  = reg_wr_in && (reg_addr_in == DBXC_ADDR_FEATURE) &&
	                        |(reg_wdata_in & ~DBXC_FEATURE_VALID);
	wire logic sreg_rsvd  = sreg_wr_in && |(sreg_wdata_in & sreg_rsvd_mask_in);

	// ----------------------------------------
	// Breakpoint matching
	// ----------------------------------------
	wire logic [3:0] bp_hit;
	for (genvar g = 0; g < 4; g++) begin : g_bp
		dbxc_bp_match u_match (
			.bp_addr_in          (bp_addr_q[g]),
			.access_type_in      (debug_control_reg_q[DBXC_DCTRL_TYPE_LSB + 4*g +: 2]),
			.bp_len_in           (debug_control_reg_q[DBXC_DCTRL_LEN_LSB + 4*g +: 2]),
			.debug_ext_enable_in (debug_ext_enable),
			.acc_valid_in        (acc_valid_in && debug_control_reg_q[2*g +: 2] != 2'h0),
			.acc_kind_in         (acc_kind_in),
			.acc_addr_in         (acc_addr_in),
			.hit_out             (bp_hit[g])
		);
	end

	// ----------------------------------------
	// Fault detection
	// ----------------------------------------
	// Misalignment check from size code: 1, 2, 4, 8 bytes
	function automatic logic misaligned(input logic [31:0] a, input logic [1:0] sz);
		logic [2:0] m;
		m = 3'((4'h1 << sz) - 4'h1);
		return |(a[2:0] & m);
	endfunction : misaligned

	// Signed quotient fits if in range; the most negative value is legal
	function automatic logic quot_ovf(input logic [32:0] q, input logic w);
		logic [32:0] s;
		s = w ? 33'(signed'(q[15:0])) : 33'(signed'(q[7:0]));
		return s != q;
	endfunction : quot_ovf

	wire logic div_err   = div_valid_in && (div_by_zero_in ||
	                       (div_signed_in && quot_ovf(div_quot_in, div_word_in)));
	wire logic align_err = acc_valid_in && align_check_active_in &&
	                       acc_kind_in != DBXC_ACC_FETCH &&
	                       misaligned(acc_addr_in, acc_size_in);
	wire logic mchk_err  = hw_error_in && machine_check_enable;
	wire logic long_err  = insn_len_ovf_in || (insn_len_in > DBXC_MAX_INSN_LEN);
	wire logic ud_dec    = test_reg_move_in || lock_misuse_in || alias_fault;
	wire logic gp_exec   = sreg_rsvd || feat_rsvd;
	wire logic bp_data   = |bp_hit && acc_kind_in != DBXC_ACC_FETCH;
	wire logic bp_fetch  = |bp_hit && acc_kind_in == DBXC_ACC_FETCH;

	// ----------------------------------------
	// Per-category selection, fixed order inside each
	// ----------------------------------------
	wire logic [7:0] trap_vec = mchk_err ? DBXC_VEC_MCHK : DBXC_VEC_DEBUG;
	wire logic [7:0] fetch_vec = bp_fetch ? DBXC_VEC_DEBUG : fetch_fault_vec_in;
	wire logic [7:0] dec_vec  = ud_dec ? DBXC_VEC_INV_OP : DBXC_VEC_GP;
	wire logic [7:0] exec_vec =
		div_err       ? DBXC_VEC_DIVIDE :
		gp_exec       ? DBXC_VEC_GP :
		pt_rsvd_set_in ? DBXC_VEC_PAGE :
		align_err     ? DBXC_VEC_ALIGN :
		DBXC_VEC_PFP;
	wire logic [4:0] cat_req = {
		div_err || gp_exec || pt_rsvd_set_in || align_err || pfp_error_in,
		ud_dec || long_err,
		fetch_fault_in || bp_fetch,
		ext_irq_in,
		prev_trap_in || mchk_err || bp_data
	};
	wire logic       win_any;
	wire logic [7:0] win_vec;
	wire logic [2:0] win_cat;

	dbxc_prio u_prio (
		.req_in  (cat_req),
		.vec_in  ({exec_vec, dec_vec, fetch_vec, ext_irq_vec_in, trap_vec}),
		.any_out (win_any),
		.vec_out (win_vec),
		.cat_out (win_cat)
	);

	// ----------------------------------------
	// Register writes
	// ----------------------------------------
	always_ff @(posedge ref_clk_in) begin
		if (rst_in) begin
			feature_control_reg_q <= DBXC_FEATURE_RESET;
			debug_control_reg_q   <= DBXC_DCTRL_RESET;
			packed_fp_ctrl_status_q <= 32'h0000_0000;
			for (int i = 0; i < 4; i++) begin
				bp_addr_q[i] <= 32'h0000_0000;
			end
		end else begin
			if (reg_wr_in && reg_addr_in == DBXC_ADDR_FEATURE && !feat_rsvd) begin
				feature_control_reg_q <= reg_wdata_in & DBXC_FEATURE_VALID;
			end
			if (reg_wr_in && sel_ctrl && !alias_fault) begin
				debug_control_reg_q <= reg_wdata_in & ~DBXC_DCTRL_RSVD_MASK;
			end
			if (reg_wr_in && sel_bp) begin
				bp_addr_q[reg_addr_in[1:0]] <= reg_wdata_in;
			end
			// Sticky flags: hardware set wins over software write
			if (reg_wr_in && reg_addr_in == DBXC_ADDR_PFP_CSR) begin
				packed_fp_ctrl_status_q <= {26'h0, reg_wdata_in[5:0] |
				                           (pfp_error_in ? pfp_flags_in : 6'h00)};
			end else if (pfp_error_in) begin
				packed_fp_ctrl_status_q[5:0] <= packed_fp_ctrl_status_q[5:0] | pfp_flags_in;
			end
		end
	end

	// Debug status: write clears bit 12, hits set low bits
	always_ff @(posedge ref_clk_in) begin
		if (rst_in) begin
			debug_status_reg_q <= DBXC_DSTATUS_RESET;
		end else if (reg_wr_in && sel_status && !alias_fault) begin
			debug_status_reg_q <= (reg_wdata_in & ~DBXC_DSTATUS_RSVD_MASK) |
			                      {28'h0, bp_hit};
		end else if (|bp_hit) begin
			debug_status_reg_q[3:0] <= debug_status_reg_q[3:0] | bp_hit;
		end
	end

	// ----------------------------------------
	// Read data, one cycle after the strobe
	// ----------------------------------------
	wire logic [31:0] rd_mux =
		alias_fault                      ? 32'h0000_0000 :
		sel_status                       ? debug_status_reg_q :
		sel_ctrl                         ? debug_control_reg_q :
		sel_bp                           ? bp_addr_q[reg_addr_in[1:0]] :
		(reg_addr_in == DBXC_ADDR_FEATURE) ? feature_control_reg_q :
		(reg_addr_in == DBXC_ADDR_PFP_CSR) ? packed_fp_ctrl_status_q :
		(reg_addr_in == DBXC_ADDR_LAST_VEC) ? {24'h0, last_vec_q} :
		32'h0000_0000;

	always_ff @(posedge ref_clk_in) begin
		if (rst_in) begin
			reg_rdata_q <= 32'h0000_0000;
		end else begin
			reg_rdata_q <= reg_rd_in ? rd_mux : 32'h0000_0000;
		end
	end

	// ----------------------------------------
	// Event delivery and descriptor outputs
	// ----------------------------------------
	always_ff @(posedge ref_clk_in) begin
		if (rst_in) begin
			event_valid_out     <= 1'b0;
			event_vec_out       <= 8'h00;
			event_cat_out       <= 3'h0;
			event_ret_ptr_out   <= 32'h0000_0000;
			last_vec_q          <= 8'h00;
			desc_locked_rmw_out <= 1'b0;
			desc_invalid_out    <= 1'b0;
		end else begin
			event_valid_out   <= win_any;
			event_vec_out     <= win_vec;
			event_cat_out     <= win_cat;
			event_ret_ptr_out <= insn_ptr_in;  // Faulting insn itself
			if (win_any) begin
				last_vec_q <= win_vec;
			end
			desc_invalid_out <= desc_load_in && (desc_ar_in == DBXC_INVALID_AR_A ||
			                    desc_ar_in == DBXC_INVALID_AR_B);
			desc_locked_rmw_out <= desc_load_in && !desc_ar_in[0] &&
			                       desc_ar_in != DBXC_INVALID_AR_B;
		end
	end

	assign reg_rdata_out            = reg_rdata_q;
	assign debug_ext_enable_out     = debug_ext_enable;
	assign machine_check_enable_out = machine_check_enable;

endmodule : dbxc_ctrl

//--- bench/dbxc_ctrl_asserts.sv
// Checker for event ranking, descriptor results and feature reset
`timescale 1ns/1ps
module dbxc_ctrl_asserts
	import dbxc_pkg::*;
(
	// Clock and reset
	input wire logic        ref_clk_in, rst_in,
	// Pipeline reports
	input wire logic        acc_valid_in, prev_trap_in, ext_irq_in, fetch_fault_in, hw_error_in,
	input wire logic        test_reg_move_in, lock_misuse_in, insn_len_ovf_in, div_valid_in,
	input wire logic        div_by_zero_in, desc_load_in,
	input wire logic [7:0]  ext_irq_vec_in, desc_ar_in,
	input wire logic [31:0] insn_ptr_in,
	// Results
	input wire logic        event_valid_out, desc_locked_rmw_out, desc_invalid_out,
	input wire logic        debug_ext_enable_out, machine_check_enable_out,
	input wire logic [7:0]  event_vec_out,
	input wire logic [2:0]  event_cat_out,
	input wire logic [31:0] event_ret_ptr_out
);
	default clocking @(posedge ref_clk_in);
	endclocking
	default disable iff (rst_in);

	// Nothing ranked above decode is pending
	wire quiet = !acc_valid_in && !prev_trap_in && !ext_irq_in && !fetch_fault_in && !hw_error_in;

	// Invalid-opcode delivery in the decode category
	sequence ud_seq;
		event_valid_out && event_vec_out == DBXC_VEC_INV_OP && event_cat_out == 3'h3;
	endsequence

	feat_reset_a: assert property (
		$fell(rst_in) |-> !debug_ext_enable_out && !machine_check_enable_out)
		else $error("feature enables set after reset");
	mchk_gate_a: assert property (
		event_valid_out && event_cat_out == 3'h0 && event_vec_out == DBXC_VEC_MCHK |->
		$past(machine_check_enable_out) && $past(hw_error_in))
		else $error("machine check without enable");
	test_reg_a: assert property (test_reg_move_in && quiet |=> ud_seq)
		else $error("test register move not invalid opcode");
	lock_ud_a: assert property (lock_misuse_in && quiet |=> ud_seq)
		else $error("lock misuse not invalid opcode");
	len_gp_a: assert property (
		insn_len_ovf_in && quiet && !test_reg_move_in && !lock_misuse_in |=>
		event_valid_out && event_vec_out == DBXC_VEC_GP && event_cat_out == 3'h3)
		else $error("long instruction not protection fault");
	div_ptr_a: assert property (
		div_valid_in && div_by_zero_in && quiet && !test_reg_move_in && !lock_misuse_in &&
		!insn_len_ovf_in |=> event_vec_out == DBXC_VEC_DIVIDE &&
		event_ret_ptr_out == $past(insn_ptr_in))
		else $error("divide error pointer wrong");
	trap_first_a: assert property (
		prev_trap_in |=> event_valid_out && event_cat_out == 3'h0)
		else $error("prior trap not ranked first");
	irq_second_a: assert property (
		ext_irq_in && !prev_trap_in && !hw_error_in && !acc_valid_in |=>
		event_cat_out == 3'h1 && event_vec_out == $past(ext_irq_vec_in))
		else $error("interrupt not ranked second");
	desc_rmw_a: assert property (
		desc_load_in |=> desc_locked_rmw_out == (($past(desc_ar_in) & 8'h01) == 8'h00 &&
		$past(desc_ar_in) != DBXC_INVALID_AR_B))
		else $error("locked update wrong");
	desc_inv_a: assert property (
		desc_load_in |=> desc_invalid_out == ($past(desc_ar_in) == DBXC_INVALID_AR_A ||
		$past(desc_ar_in) == DBXC_INVALID_AR_B))
		else $error("invalid descriptor type wrong");
endmodule : dbxc_ctrl_asserts

bind dbxc_ctrl dbxc_ctrl_asserts dbxc_ctrl_asserts_i (.ref_clk_in, .rst_in, .acc_valid_in,
	.prev_trap_in, .ext_irq_in, .fetch_fault_in, .hw_error_in, .test_reg_move_in,
	.lock_misuse_in, .insn_len_ovf_in, .div_valid_in, .div_by_zero_in, .desc_load_in,
	.ext_irq_vec_in, .desc_ar_in, .insn_ptr_in, .event_valid_out, .desc_locked_rmw_out,
	.desc_invalid_out, .debug_ext_enable_out, .machine_check_enable_out, .event_vec_out,
	.event_cat_out, .event_ret_ptr_out);

//--- bench/dbxc_pipe_model.sv
// Pipeline model issuing fetch, decode and execute reports
`timescale 1ns/1ps
module dbxc_pipe_model
	import dbxc_pkg::*;
(
	// Clock
	input  wire logic   ref_clk_in,
	// Report pulses and their qualifiers
	output logic [15:0] rep_out,
	output dbxc_acc_t   kind_out,
	output logic [31:0] addr_out,
	output logic [32:0] quot_out
);
	// Idle reports at time zero
	initial begin
		rep_out = 16'h0;
		kind_out = DBXC_ACC_FETCH;
		addr_out = 32'h0;
		quot_out = 33'h0;
	end

	// One-cycle report, released with a scrambled address
	task automatic issue(input logic [15:0] m, input dbxc_acc_t k, input logic [31:0] a,
		input logic [32:0] q);
		@(posedge ref_clk_in);
		rep_out <= m;
		kind_out <= k;
		addr_out <= a;
		quot_out <= q;
		@(posedge ref_clk_in);
		rep_out <= 16'h0;
		addr_out <= ~a;
	endtask : issue
endmodule : dbxc_pipe_model

//--- bench/dbxc_ctrl_tb.sv
// Testbench for the debug breakpoint and exception controller
`timescale 1ns/1ps
module dbxc_ctrl_tb;
	import dbxc_pkg::*;

	// ----------------------------------------
	// Signals
	// ----------------------------------------
	logic        ref_clk_in, rst_in, reg_wr_in, reg_rd_in, hit;
	logic [3:0]  reg_addr_in;
	logic [31:0] reg_wdata_in, reg_rdata_out, addr, event_ret_ptr_out;
	logic [15:0] rep;
	logic [32:0] quot;
	dbxc_acc_t   kind;
	logic [7:0]  event_vec_out;
	logic [2:0]  event_cat_out;
	logic        event_valid_out, desc_locked_rmw_out, desc_invalid_out;
	logic        debug_ext_enable_out, machine_check_enable_out;
	int          num_errors = 0;
	int          checked = 0;
	logic [7:0]  ladder_vec [4] = '{8'h40, 8'h0e, 8'h06, 8'h00};
	logic [15:0] ladder_rep [4] = '{16'h01ac, 16'h01a8, 16'h01a0, 16'h0180};
	logic [7:0]  ar_tab [4] = '{8'h80, 8'h00, 8'h92, 8'h93};
	logic [1:0]  ar_exp [4] = '{2'h3, 2'h1, 2'h2, 2'h0};

	// ----------------------------------------
	// Instances
	// ----------------------------------------
	dbxc_pipe_model pipe_i (.ref_clk_in, .rep_out(rep), .kind_out(kind), .addr_out(addr),
		.quot_out(quot));
	dbxc_ctrl dbxc_ctrl_i (
		.ref_clk_in, .rst_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in, .reg_rd_in, .reg_rdata_out,
		.acc_valid_in(rep[0]), .acc_kind_in(kind), .acc_addr_in(addr), .acc_size_in(2'h2),
		.align_check_active_in(rep[15]), .test_reg_move_in(rep[4]), .lock_misuse_in(rep[5]),
		.insn_len_in(addr[3:0]), .insn_len_ovf_in(rep[6]), .fetch_fault_in(rep[3]),
		.fetch_fault_vec_in(addr[15:8]), .insn_ptr_in(addr), .div_valid_in(rep[7]),
		.div_signed_in(1'b1), .div_word_in(rep[9]), .div_quot_in(quot), .div_by_zero_in(rep[8]),
		.pt_rsvd_set_in(rep[10]), .pfp_error_in(rep[11]), .pfp_flags_in(addr[5:0]),
		.hw_error_in(rep[12]), .prev_trap_in(rep[1]), .ext_irq_in(rep[2]),
		.ext_irq_vec_in(addr[7:0]), .sreg_wr_in(rep[13]), .sreg_wdata_in(addr),
		.sreg_rsvd_mask_in(32'hffff_0000), .desc_load_in(rep[14]), .desc_ar_in(addr[7:0]),
		.event_valid_out, .event_vec_out, .event_cat_out, .event_ret_ptr_out,
		.desc_locked_rmw_out, .desc_invalid_out, .debug_ext_enable_out, .machine_check_enable_out);

	// ----------------------------------------
	// Clock and tasks
	// ----------------------------------------
	initial begin
		ref_clk_in = 1'b0;
		forever #12.5 ref_clk_in = ~ref_clk_in;
	end

	// Compare and count
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		checked++;
		if (got !== exp) begin
			num_errors++;
			$display("BAD %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask : chk
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge ref_clk_in);
		reg_addr_in <= a;
		reg_wdata_in <= d;
		reg_wr_in <= 1'b1;
		@(posedge ref_clk_in);
		reg_wr_in <= 1'b0;
	endtask : wr
	// Read, then compare the masked data in the answer cycle
	task automatic rd(input logic [3:0] a, input logic [31:0] m, input logic [31:0] exp);
		@(posedge ref_clk_in);
		reg_addr_in <= a;
		reg_rd_in <= 1'b1;
		@(posedge ref_clk_in);
		reg_rd_in <= 1'b0;
		@(negedge ref_clk_in);
		chk(reg_rdata_out & m, exp, "read");
	endtask : rd

	// Issue reports, then compare the delivered event
	task automatic ev(input logic [15:0] m, input dbxc_acc_t k, input logic [31:0] a,
		input logic [32:0] q, input logic v, input logic [7:0] e_vec, input logic [2:0] e_cat);
		pipe_i.issue(m, k, a, q);
		@(negedge ref_clk_in);
		chk({20'h0, event_valid_out, event_valid_out ? {event_vec_out, event_cat_out} : 11'h0},
			{20'h0, v, e_vec, e_cat}, "event");
	endtask : ev

	task automatic wrap_up();
		$display("checks %0d mismatches %0d", checked, num_errors);
		if (num_errors == 0 && checked > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : wrap_up

	// Watchdog well beyond the roughly 150 cycles the tests need
	initial begin
		repeat (5000) @(posedge ref_clk_in);
		num_errors++;
		$display("BAD %0t timeout", $time);
		wrap_up();
	end

	// ----------------------------------------
	// Tests
	// ----------------------------------------
	initial begin
		rst_in = 1'b1;
		reg_wr_in = 1'b0;
		reg_rd_in = 1'b0;
		reg_addr_in = 4'h0;
		reg_wdata_in = 32'h0;
		repeat (10) @(posedge ref_clk_in);
		rst_in <= 1'b0;
		rd(DBXC_ADDR_FEATURE, '1, DBXC_FEATURE_RESET);
		rd(DBXC_ADDR_DCTRL, '1, DBXC_DCTRL_RESET);
		rd(DBXC_ADDR_DSTATUS, '1, DBXC_DSTATUS_RESET);
		$display("reset values done");
		wr(DBXC_ADDR_DCTRL, 32'hffff_ffff);
		rd(DBXC_ADDR_DCTRL, DBXC_DCTRL_RSVD_MASK, 32'h0);
		wr(DBXC_ADDR_DSTATUS, 32'hffff_ffff);
		rd(DBXC_ADDR_DSTATUS, DBXC_DSTATUS_RSVD_MASK, 32'h0);
		wr(DBXC_ADDR_DSTATUS, 32'h0);
		$display("reserved bits done");
		wr(DBXC_ADDR_FEATURE, 32'h8);
		wr(DBXC_ADDR_DR0, 32'h0000_1000);
		for (int t = 0; t < 4; t++) begin
			wr(DBXC_ADDR_DCTRL, 32'h1 | (32'(t) << DBXC_DCTRL_TYPE_LSB));
			for (int k = 0; k < 4; k++) begin
				hit = t == 0 ? k == 0 : t == 1 ? k == 2 : t == 2 ? k == 3 : (k == 1 || k == 2);
				ev(16'h1, dbxc_acc_t'(k), 32'h1000, 33'h0, hit, hit ? DBXC_VEC_DEBUG : 8'h0,
					(hit && k == 0) ? 3'h2 : 3'h0);
			end
		end
		$display("breakpoint types done");
		wr(DBXC_ADDR_FEATURE, 32'h0);
		rd(DBXC_ADDR_ALIAS_FOUR, 32'h1, 32'h1);
		wr(DBXC_ADDR_ALIAS_FIVE, 32'h2);
		rd(DBXC_ADDR_DCTRL, 32'h3, 32'h2);
		wr(DBXC_ADDR_FEATURE, 32'h8);
		rd(DBXC_ADDR_ALIAS_FIVE, '1, 32'h0);
		chk({23'h0, event_valid_out, event_vec_out}, {23'h0, 1'b1, DBXC_VEC_INV_OP}, "alias");
		wr(DBXC_ADDR_FEATURE, 32'h0);
		wr(DBXC_ADDR_DCTRL, 32'h0);
		$display("alias done");
		ev(16'h1000, DBXC_ACC_FETCH, 32'h0, 33'h0, 1'b0, 8'h0, 3'h0);
		wr(DBXC_ADDR_FEATURE, 32'h40);
		ev(16'h1000, DBXC_ACC_FETCH, 32'h0, 33'h0, 1'b1, DBXC_VEC_MCHK, 3'h0);
		wr(DBXC_ADDR_FEATURE, 32'h0);
		$display("machine check done");
		pipe_i.issue(16'h01ae, DBXC_ACC_FETCH, 32'h0e40, 33'h0);
		@(negedge ref_clk_in);
		chk({28'h0, event_valid_out, event_cat_out}, 32'h8, "rank");
		for (int i = 0; i < 4; i++) begin
			ev(ladder_rep[i], DBXC_ACC_FETCH, 32'h0e40, 33'h0, 1'b1, ladder_vec[i],
				3'(i + 1));
		end
		chk(event_ret_ptr_out, 32'h0000_0e40, "return pointer");
		$display("ranking done");
		ev(16'h0010, DBXC_ACC_FETCH, 32'h0, 33'h0, 1'b1, DBXC_VEC_INV_OP, 3'h3);
		ev(16'h0040, DBXC_ACC_FETCH, 32'h0, 33'h0, 1'b1, DBXC_VEC_GP, 3'h3);
		ev(16'h0060, DBXC_ACC_FETCH, 32'h0, 33'h0, 1'b1, DBXC_VEC_INV_OP, 3'h3);
		$display("decode faults done");
		ev(16'h0400, DBXC_ACC_FETCH, 32'h0, 33'h0, 1'b1, DBXC_VEC_PAGE, 3'h4);
		ev(16'h8001, DBXC_ACC_READ, 32'h1001, 33'h0, 1'b1, DBXC_VEC_ALIGN, 3'h4);
		ev(16'h8001, DBXC_ACC_READ, 32'h1000, 33'h0, 1'b0, 8'h0, 3'h0);
		ev(16'h0800, DBXC_ACC_FETCH, 32'h2d, 33'h0, 1'b1, DBXC_VEC_PFP, 3'h4);
		rd(DBXC_ADDR_PFP_CSR, 32'h3f, 32'h2d);
		ev(16'h2000, DBXC_ACC_FETCH, 32'h0001_0000, 33'h0, 1'b1, DBXC_VEC_GP, 3'h4);
		ev(16'h2000, DBXC_ACC_FETCH, 32'h0000_ffff, 33'h0, 1'b0, 8'h0, 3'h0);
		ev(16'h0080, DBXC_ACC_FETCH, 32'h0, 33'h1_ffff_ff80, 1'b0, 8'h0, 3'h0);
		ev(16'h0080, DBXC_ACC_FETCH, 32'h0, 33'h1_ffff_ff7f, 1'b1, DBXC_VEC_DIVIDE, 3'h4);
		ev(16'h0280, DBXC_ACC_FETCH, 32'h0, 33'h1_ffff_8000, 1'b0, 8'h0, 3'h0);
		ev(16'h0280, DBXC_ACC_FETCH, 32'h0, 33'h0_0000_8000, 1'b1, DBXC_VEC_DIVIDE, 3'h4);
		$display("execute faults done");
		for (int i = 0; i < 4; i++) begin
			pipe_i.issue(16'h4000, DBXC_ACC_FETCH, {24'h0, ar_tab[i]}, 33'h0);
			@(negedge ref_clk_in);
			chk({30'h0, desc_locked_rmw_out, desc_invalid_out}, {30'h0, ar_exp[i]}, "desc");
		end
		$display("descriptors done");
		wr(DBXC_ADDR_FEATURE, 32'h48);
		rd(DBXC_ADDR_FEATURE, '1, 32'h48);
		chk({30'h0, debug_ext_enable_out, machine_check_enable_out}, 32'h3, "enables on");
		@(posedge ref_clk_in);
		rst_in <= 1'b1;
		repeat (2) @(posedge ref_clk_in);
		rst_in <= 1'b0;
		@(negedge ref_clk_in);
		chk({30'h0, debug_ext_enable_out, machine_check_enable_out}, 32'h0, "enables");
		rd(DBXC_ADDR_FEATURE, '1, 32'h0);
		$display("second reset done");
		wrap_up();
	end
endmodule : dbxc_ctrl_tb
